// ==== verilog/pdc_consts.svh ====
// Offsets, field positions, reset values and frame counts
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH
`define PDC_OFS_POWER      7'h08
`define PDC_OFS_OUT_PD     7'h09
`define PDC_OFS_MASK       7'h0d
`define PDC_OFS_SYNC_CFG   7'h0e
`define PDC_RESET_VAL      8'h00
`define PDC_IDX_POWER      2'h0
`define PDC_IDX_OUT_PD     2'h1
`define PDC_IDX_MASK       2'h2
`define PDC_IDX_SYNC_CFG   2'h3
`define PDC_BIT_GSLEEP     0
`define PDC_BIT_FRAME_OFF  5
`define PDC_BIT_BCLK_OFF   4
`define PDC_BIT_A1_OFF     3
`define PDC_BIT_A0_OFF     2
`define PDC_BIT_B1_OFF     1
`define PDC_BIT_B0_OFF     0
`define PDC_BIT_KEEP_CLK   3
`define PDC_BIT_KEEP_RAMP  2
`define PDC_BIT_BG_OFF     1
`define PDC_BIT_PIN_SYNC   7
`define PDC_BIT_SW_SYNC    6
`define PDC_BIT_SW_SYNC_EN 5
`define PDC_BIT_REF_SOURCE 3
`define PDC_BIT_REF_SEL_HI 2
`define PDC_BIT_REF_SEL_LO 1
`define PDC_BIT_SE_CLK     0
`define PDC_FRAME_BITS     5'h10
`define PDC_ADDR_BITS      5'h08
`endif

// ==== verilog/pdc_pkg.sv ====
// Types shared by the power-down control register bank
package pdc_pkg;
    typedef logic [7:0] pdc_byte_t;
    typedef logic [6:0] pdc_addr_t;
    typedef logic [1:0] pdc_idx_t;
    typedef logic [4:0] pdc_cnt_t;
endpackage

// ==== verilog/pdc_serial_port.sv ====
// Serial control port: 16-bit frames, read flag, address, data
`timescale 1ns/1ns
`default_nettype none
`include "pdc_consts.svh"
module pdc_serial_port
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Serial pins
    input  wire logic         spi_cs_n,
    input  wire logic         spi_sclk,
    input  wire logic         spi_sdi,
    output var  logic         spi_sdo,
    output var  logic         spi_sdo_en,
    // Register side
    input  wire pdc_pkg::pdc_byte_t rd_data,
    output var  pdc_pkg::pdc_addr_t addr,
    output var  pdc_pkg::pdc_byte_t wr_data,
    output var  logic         wr_stb
);
    import pdc_pkg::*;

    logic      sclk_r, sclk_nxt;
    pdc_cnt_t  cnt_r, cnt_nxt;
    logic [15:0] sh_r, sh_nxt;
    pdc_byte_t out_r, out_nxt;
    logic      rd_r, rd_nxt;
    pdc_addr_t addr_r, addr_nxt;
    logic      stb_r, stb_nxt;
    logic      oe_r, oe_nxt;
    logic      rise, fall;

    assign rise = spi_sclk & ~sclk_r;
    assign fall = ~spi_sclk & sclk_r;

    always_comb
    begin
        sclk_nxt = spi_sclk;
        cnt_nxt  = cnt_r;
        sh_nxt   = sh_r;
        out_nxt  = out_r;
        rd_nxt   = rd_r;
        addr_nxt = addr_r;
        stb_nxt  = 1'b0;
        oe_nxt   = oe_r;
        if (spi_cs_n)
        begin
            // Deselect aborts any partial frame
            cnt_nxt = 5'h00;
            oe_nxt  = 1'b0;
        end
        else if (rise && cnt_r < `PDC_FRAME_BITS)
        begin
            sh_nxt  = {sh_r[14:0], spi_sdi};
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `PDC_ADDR_BITS - 5'h01)
            begin
                rd_nxt   = sh_r[6];
                addr_nxt = {sh_r[5:0], spi_sdi};
            end
            if (cnt_r == `PDC_FRAME_BITS - 5'h01)
                stb_nxt = ~rd_r;
        end
        else if (fall && rd_r && cnt_r >= `PDC_ADDR_BITS)
        begin
            // First falling edge loads, later ones shift
            if (cnt_r == `PDC_ADDR_BITS)
                out_nxt = rd_data;
            else
                out_nxt = {out_r[6:0], 1'b0};
            oe_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_r <= 1'b0;
            cnt_r  <= 5'h00;
            sh_r   <= 16'h0000;
            out_r  <= 8'h00;
            rd_r   <= 1'b0;
            addr_r <= 7'h00;
            stb_r  <= 1'b0;
            oe_r   <= 1'b0;
        end
        else
        begin
            sclk_r <= sclk_nxt;
            cnt_r  <= cnt_nxt;
            sh_r   <= sh_nxt;
            out_r  <= out_nxt;
            rd_r   <= rd_nxt;
            addr_r <= addr_nxt;
            stb_r  <= stb_nxt;
            oe_r   <= oe_nxt;
        end
    end

    assign spi_sdo    = out_r[7];
    assign spi_sdo_en = oe_r;
    assign addr       = addr_r;
    assign wr_data    = sh_r[7:0];
    assign wr_stb     = stb_r;
endmodule
`default_nettype wire

// ==== verilog/pdc_regs.sv ====
// Power-down, mask and sync/reference register bank with its controls
// How it works
// - Bit 5 of output power-down register turns frame clock buffer off.
// - Bit 4 turns bit clock buffer off; zero keeps it driving.
// - Bit 3 turns channel A lane 1 off; format never does.
// - Bit 2 turns channel A lane 0 off; zero keeps it on.
// - Bit 1 turns channel B lane 1 off; format never does.
// - Bit 0 turns channel B lane 0 off; format never does.
// - In sleep, sample clock buffer off unless mask bit 3 set.
// - In sleep, reference amplifier off unless mask bit 2 set.
// - In sleep, bandgap off only when mask bit 1 set.
// - Sync/reference layout bits 7,6,5,3,2-1,0; resets to zero.
// - Software sleep bit 0 enters global sleep, mask picks victims.
// - Shared pin high sleeps when bit 7 clear, syncs when set.
// - Toggling bit 6 syncs only when enabled; host clears it.
`timescale 1ns/1ns
`default_nettype none
`include "pdc_consts.svh"
module pdc_regs
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Serial control port
    input  wire logic         spi_cs_n,
    input  wire logic         spi_sclk,
    input  wire logic         spi_sdi,
    output var  logic         spi_sdo,
    output var  logic         spi_sdo_en,
    // Shared sync / sleep pin
    input  wire logic         sync_sleep_pin,
    // Output buffer controls
    output var  logic         frame_clock_out_off,
    output var  logic         bit_clock_out_off,
    output var  logic         chan_a_lane_one_off,
    output var  logic         chan_a_lane_zero_off,
    output var  logic         chan_b_lane_one_off,
    output var  logic         chan_b_lane_zero_off,
    // Analog block controls
    output var  logic         global_sleep,
    output var  logic         sample_clock_buffer_off,
    output var  logic         reference_amplifier_off,
    output var  logic         bandgap_off,
    // Sync and reference
    output var  logic         sync_pulse,
    output var  logic         reference_source_control,
    output var  logic [1:0]   reference_select,
    output var  logic         single_ended_clock_enable
);
    import pdc_pkg::*;

    pdc_addr_t addr;
    pdc_byte_t wr_data;
    pdc_byte_t rd_data;
    logic      wr_stb;
    logic      hit;
    pdc_idx_t  idx;

    pdc_byte_t bank_r [4];
    pdc_byte_t bank_nxt [4];
    logic      pin_r, pin_nxt;
    logic      tog_r, tog_nxt;
    logic [5:0] buf_r, buf_nxt;
    logic [3:0] ana_r, ana_nxt;
    logic      sync_r, sync_nxt;
    logic [3:0] ref_r, ref_nxt;
    logic      sleep_now;

    pdc_serial_port u_port
    (
        .clk        (clk),
        .resetn     (resetn),
        .spi_cs_n   (spi_cs_n),
        .spi_sclk   (spi_sclk),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_en (spi_sdo_en),
        .rd_data    (rd_data),
        .addr       (addr),
        .wr_data    (wr_data),
        .wr_stb     (wr_stb)
    );

    // Decode shared by read and write paths
    function automatic logic [2:0] decode(input pdc_addr_t a);
        case (a)
            `PDC_OFS_POWER:    decode = {1'b1, `PDC_IDX_POWER};
            `PDC_OFS_OUT_PD:   decode = {1'b1, `PDC_IDX_OUT_PD};
            `PDC_OFS_MASK:     decode = {1'b1, `PDC_IDX_MASK};
            `PDC_OFS_SYNC_CFG: decode = {1'b1, `PDC_IDX_SYNC_CFG};
            default:           decode = 3'h0;
        endcase
    endfunction

    assign {hit, idx} = decode(addr);
    // read-back of stored value, unmapped reads zero
    assign rd_data = hit ? bank_r[idx] : 8'h00;

    // Register writes
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            bank_nxt[i] = bank_r[i];
        if (wr_stb && hit)
            bank_nxt[idx] = wr_data;
    end

    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_bank
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                    bank_r[g] <= `PDC_RESET_VAL;
                else
                    bank_r[g] <= bank_nxt[g];
            end
        end
    endgenerate

    // Control decode from stored settings
    always_comb
    begin
        pin_nxt = sync_sleep_pin;
        tog_nxt = bank_r[`PDC_IDX_SYNC_CFG][`PDC_BIT_SW_SYNC];
        // pin sleeps only when sync use is off
        sleep_now = bank_r[`PDC_IDX_POWER][`PDC_BIT_GSLEEP]
            | (sync_sleep_pin
               & ~bank_r[`PDC_IDX_SYNC_CFG][`PDC_BIT_PIN_SYNC]);
        buf_nxt = bank_r[`PDC_IDX_OUT_PD][5:0];
        // sleep flag, clock buffer, ref amp, bandgap with mask not inverted
        ana_nxt[3] = sleep_now;
        ana_nxt[2] = sleep_now
            & ~bank_r[`PDC_IDX_MASK][`PDC_BIT_KEEP_CLK];
        ana_nxt[1] = sleep_now
            & ~bank_r[`PDC_IDX_MASK][`PDC_BIT_KEEP_RAMP];
        ana_nxt[0] = sleep_now
            & bank_r[`PDC_IDX_MASK][`PDC_BIT_BG_OFF];
        // pin rising edge syncs when bit 7 set
        // a change of bit 6 syncs while enabled
        sync_nxt = (sync_sleep_pin & ~pin_r
                    & bank_r[`PDC_IDX_SYNC_CFG][`PDC_BIT_PIN_SYNC])
            | ((tog_nxt ^ tog_r)
               & bank_r[`PDC_IDX_SYNC_CFG][`PDC_BIT_SW_SYNC_EN]);
        ref_nxt = {bank_r[`PDC_IDX_SYNC_CFG][`PDC_BIT_REF_SOURCE],
                   bank_r[`PDC_IDX_SYNC_CFG][`PDC_BIT_REF_SEL_HI],
                   bank_r[`PDC_IDX_SYNC_CFG][`PDC_BIT_REF_SEL_LO],
                   bank_r[`PDC_IDX_SYNC_CFG][`PDC_BIT_SE_CLK]};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_r  <= 1'b0;
            tog_r  <= 1'b0;
            buf_r  <= 6'h00;
            ana_r  <= 4'h0;
            sync_r <= 1'b0;
            ref_r  <= 4'h0;
        end
        else
        begin
            pin_r  <= pin_nxt;
            tog_r  <= tog_nxt;
            buf_r  <= buf_nxt;
            ana_r  <= ana_nxt;
            sync_r <= sync_nxt;
            ref_r  <= ref_nxt;
        end
    end

    assign frame_clock_out_off       = buf_r[`PDC_BIT_FRAME_OFF];
    assign bit_clock_out_off         = buf_r[`PDC_BIT_BCLK_OFF];
    assign chan_a_lane_one_off       = buf_r[`PDC_BIT_A1_OFF];
    assign chan_a_lane_zero_off      = buf_r[`PDC_BIT_A0_OFF];
    assign chan_b_lane_one_off       = buf_r[`PDC_BIT_B1_OFF];
    assign chan_b_lane_zero_off      = buf_r[`PDC_BIT_B0_OFF];
    assign global_sleep              = ana_r[3];
    assign sample_clock_buffer_off   = ana_r[2];
    assign reference_amplifier_off   = ana_r[1];
    assign bandgap_off               = ana_r[0];
    assign sync_pulse                = sync_r;
    assign reference_source_control  = ref_r[3];
    assign reference_select          = ref_r[2:1];
    assign single_ended_clock_enable = ref_r[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_FRAME_OFF: assert property (
        $past(bank_r[1][5]) |-> frame_clock_out_off)
        else $error("frame clock buffer not off");
    AST_BCLK_ON: assert property (
        !$past(bank_r[1][4]) |-> !bit_clock_out_off)
        else $error("bit clock buffer wrongly off");
    AST_LANES: assert property (
        {chan_a_lane_one_off, chan_a_lane_zero_off,
         chan_b_lane_one_off, chan_b_lane_zero_off}
        == $past(bank_r[1][3:0]))
        else $error("lane buffer control mismatch");
    AST_CLKBUF: assert property (
        global_sleep && !$past(bank_r[2][3]) |-> sample_clock_buffer_off)
        else $error("clock buffer not off in sleep");
    AST_REFAMP: assert property (
        $past(bank_r[2][2]) |-> !reference_amplifier_off)
        else $error("reference amplifier off despite mask");
    AST_BANDGAP: assert property (
        bandgap_off |-> global_sleep && $past(bank_r[2][1]))
        else $error("bandgap off without mask bit");
    AST_SW_SLEEP: assert property (
        bank_r[0][0] |=> global_sleep)
        else $error("software sleep ignored");
    AST_PIN_SLEEP: assert property (
        sync_sleep_pin && !bank_r[3][7] |=> global_sleep)
        else $error("pin sleep ignored");
    AST_SYNC_EN: assert property (
        sync_pulse && !$past(sync_sleep_pin) |-> $past(bank_r[3][5]))
        else $error("software sync while disabled");
    AST_READBACK: assert property (
        wr_stb && hit |=> bank_r[$past(idx)] == $past(wr_data))
        else $error("write not stored");
    AST_REF: assert property (
        ##1 reference_select == $past(bank_r[3][2:1]))
        else $error("reference select mismatch");
    AST_REF_SOURCE: assert property (
        reference_source_control == $past(bank_r[3][3]))
        else $error("reference source control mismatch");
    AST_SINGLE_CLK: assert property (
        single_ended_clock_enable == $past(bank_r[3][0]))
        else $error("single ended clock mismatch");
    // Outputs lag the bank by one clock, so they compare with past values
    AST_FRAME_ON: assert property (
        !$past(bank_r[1][5]) |-> !frame_clock_out_off)
        else $error("frame clock buffer wrongly off");
    AST_BIT_CLK_OFF: assert property (
        $past(bank_r[1][4]) |-> bit_clock_out_off)
        else $error("bit clock buffer not off");
    AST_LANE_A1: assert property (
        chan_a_lane_one_off == $past(bank_r[1][3]))
        else $error("lane A1 buffer control mismatch");
    AST_LANE_A0: assert property (
        chan_a_lane_zero_off == $past(bank_r[1][2]))
        else $error("lane A0 buffer control mismatch");
    AST_LANE_B1: assert property (
        chan_b_lane_one_off == $past(bank_r[1][1]))
        else $error("lane B1 buffer control mismatch");
    AST_LANE_B0: assert property (
        chan_b_lane_zero_off == $past(bank_r[1][0]))
        else $error("lane B0 buffer control mismatch");
    AST_CLK_KEPT: assert property (
        $past(bank_r[2][3]) |-> !sample_clock_buffer_off)
        else $error("clock buffer off despite mask");
    AST_REF_AMP_SLEEP: assert property (
        global_sleep && !$past(bank_r[2][2]) |-> reference_amplifier_off)
        else $error("reference amplifier not off in sleep");
    AST_BANDGAP_SLEEP: assert property (
        global_sleep && $past(bank_r[2][1]) |-> bandgap_off)
        else $error("bandgap not off in sleep");
    AST_AWAKE: assert property (
        !global_sleep |-> !sample_clock_buffer_off && !reference_amplifier_off
            && !bandgap_off)
        else $error("analog block off while awake");
    AST_SLEEP_SOURCE: assert property (
        global_sleep |-> $past(bank_r[0][0])
            || ($past(sync_sleep_pin) && !$past(bank_r[3][7])))
        else $error("sleep without a source");
    AST_PIN_SYNC: assert property (
        $rose(sync_sleep_pin) && bank_r[3][7] |=> sync_pulse)
        else $error("pin sync not issued");
    AST_PIN_NO_SYNC: assert property (
        $rose(sync_sleep_pin) && !bank_r[3][7] && !$changed(bank_r[3][6])
        |=> !sync_pulse)
        else $error("pin sync while pin sleeps");
    AST_SW_SYNC: assert property (
        $changed(bank_r[3][6]) && bank_r[3][5] |=> sync_pulse)
        else $error("software sync not issued");
    AST_SW_NO_SYNC: assert property (
        $changed(bank_r[3][6]) && !bank_r[3][5] && !$rose(sync_sleep_pin)
        |=> !sync_pulse)
        else $error("software sync issued while disabled");
    AST_UNMAPPED: assert property (
        !hit |-> rd_data == 8'h00)
        else $error("unmapped read not zero");
    AST_HOLD_OUT_PD: assert property (
        !(wr_stb && hit && idx == `PDC_IDX_OUT_PD) |=> $stable(bank_r[1]))
        else $error("output power-down register changed without a write");
    AST_HOLD_SYNC_CFG: assert property (
        !(wr_stb && hit && idx == `PDC_IDX_SYNC_CFG) |=> $stable(bank_r[3]))
        else $error("sync configuration changed without a write");

    COV_SLEEP: cover property (global_sleep && bandgap_off);
    COV_SYNC: cover property (sync_pulse);
    COV_WRITE: cover property (wr_stb && hit ##1 frame_clock_out_off);
    COV_SW_SYNC: cover property ($changed(bank_r[3][6]) && bank_r[3][5]);
    COV_PIN_SYNC: cover property ($rose(sync_sleep_pin) && bank_r[3][7]);
endmodule
`default_nettype wire

// ==== bench/powerdown_control_regs_bench.sv ====
// Self-checking bench for the power-down control register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("Error at %0t ns: got %h expected %h", $time, got, exp); \
        end \
    end
module powerdown_control_regs_bench;
    import pdc_pkg::*;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       spi_cs_n = 1'b1;
    logic       spi_sclk = 1'b0;
    logic       spi_sdi = 1'b0;
    logic       sync_sleep_pin = 1'b0;
    logic       spi_sdo, spi_sdo_en, fc_off, bc_off, a1_off, a0_off, b1_off, b0_off;
    logic       g_sleep, clkbuf_off, ramp_off, bg_off, sync_pulse, ref_src, se_clk;
    logic [1:0] ref_sel;
    pdc_byte_t  m_reg [4];
    integer     seed = 32'hbceb;
    int         error_cnt = 0;
    int         comparisons = 0;
    int         sync_cnt = 0;
    int         exp_sync = 0;
    int         cycles = 0;

    pdc_regs dut
    (
        .clk(clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_en(spi_sdo_en),
        .sync_sleep_pin(sync_sleep_pin), .frame_clock_out_off(fc_off),
        .bit_clock_out_off(bc_off), .chan_a_lane_one_off(a1_off),
        .chan_a_lane_zero_off(a0_off), .chan_b_lane_one_off(b1_off),
        .chan_b_lane_zero_off(b0_off), .global_sleep(g_sleep),
        .sample_clock_buffer_off(clkbuf_off), .reference_amplifier_off(ramp_off),
        .bandgap_off(bg_off), .sync_pulse(sync_pulse), .reference_source_control(ref_src),
        .reference_select(ref_sel), .single_ended_clock_enable(se_clk)
    );

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (sync_pulse === 1'b1)
            sync_cnt++;
        if (cycles == 40000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic int idx_of(input pdc_addr_t a);
        case (a)
            7'h08: return 0;
            7'h09: return 1;
            7'h0d: return 2;
            7'h0e: return 3;
            default: return -1;
        endcase
    endfunction

    // Levels held 4 clocks, three more than the port needs
    task automatic frame(input logic rd, input pdc_addr_t a, input pdc_byte_t d,
                         input int nbits, output pdc_byte_t q);
        logic [15:0] w;
        w = {rd, a, d};
        q = 8'h00;
        @(negedge clk);
        spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            spi_sclk = 1'b0;
            spi_sdi = w[15-i];
            repeat (4) @(negedge clk);
            if (i >= 8)
                q = {q[6:0], spi_sdo};
            if (rd && i == 15)
                `CHK(spi_sdo_en, 1'b1) // read drive
            spi_sclk = 1'b1;
            repeat (4) @(negedge clk);
        end
        spi_sclk = 1'b0;
        repeat (4) @(negedge clk);
        spi_cs_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    task automatic wr(input pdc_addr_t a, input pdc_byte_t d);
        pdc_byte_t q;
        int        k;
        k = idx_of(a);
        frame(1'b0, a, d, 16, q);
        if (k == 3 && d[5] && d[6] != m_reg[3][6])
            exp_sync++;
        if (k >= 0)
            m_reg[k] = d;
    endtask

    task automatic rd_chk(input pdc_addr_t a);
        pdc_byte_t q;
        int        k;
        k = idx_of(a);
        frame(1'b1, a, 8'h00, 16, q);
        `CHK(q, (k >= 0) ? m_reg[k] : 8'h00) // read back
        `CHK(spi_sdo_en, 1'b0) // released
    endtask

    task automatic set_pin(input logic v);
        @(negedge clk);
        if (v && !sync_sleep_pin && m_reg[3][7])
            exp_sync++;
        sync_sleep_pin = v;
        repeat (4) @(negedge clk);
    endtask

    task automatic check_all();
        logic gs;
        gs = m_reg[0][0] | (sync_sleep_pin & ~m_reg[3][7]);
        `CHK(fc_off, m_reg[1][5]) // frame clock
        `CHK(bc_off, m_reg[1][4]) // bit clock
        `CHK(a1_off, m_reg[1][3]) // lane A1
        `CHK(a0_off, m_reg[1][2]) // lane A0
        `CHK(b1_off, m_reg[1][1]) // lane B1
        `CHK(b0_off, m_reg[1][0]) // lane B0
        `CHK(clkbuf_off, gs & ~m_reg[2][3]) // clock buffer
        `CHK(ramp_off, gs & ~m_reg[2][2]) // amplifier
        `CHK(bg_off, gs & m_reg[2][1]) // bandgap
        `CHK(g_sleep, gs) // sleep source
        `CHK({ref_src, ref_sel, se_clk}, {m_reg[3][3], m_reg[3][2:1], m_reg[3][0]})
        `CHK(sync_cnt, exp_sync) // sync count
    endtask

    task automatic read_all();
        foreach (m_reg[k])
            rd_chk(k == 0 ? 7'h08 : k == 1 ? 7'h09 : k == 2 ? 7'h0d : 7'h0e);
    endtask

    initial
    begin
        pdc_byte_t q;
        foreach (m_reg[k])
            m_reg[k] = 8'h00;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        check_all();
        read_all();
        // Reserved bits kept zero on purpose
        repeat (16)
        begin
            wr(7'h09, 8'($random(seed)) & 8'h3f);
            wr(7'h0d, 8'($random(seed)) & 8'h0e);
            wr(7'h08, 8'($random(seed)) & 8'h01);
            wr(7'h0e, 8'($random(seed)) & 8'h8f);
            set_pin(1'($random(seed)));
            check_all();
            read_all();
        end
        // Corners: every mask with sleep on, then cut frame and holes
        wr(7'h0e, 8'h00);
        wr(7'h08, 8'h01);
        for (int m = 0; m < 8; m++)
        begin
            wr(7'h0d, 8'(m << 1));
            check_all();
        end
        wr(7'h09, 8'h15);
        frame(1'b0, 7'h09, 8'h2a, 10, q);
        wr(7'h20, 8'hff);
        rd_chk(7'h20);
        rd_chk(7'h0a);
        check_all();
        read_all();
        // Mid-run reset clears the bank; pin left as it was
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        foreach (m_reg[k])
            m_reg[k] = 8'h00;
        repeat (2) @(negedge clk);
        check_all();
        read_all();
        // Software sync sequence, then pin sync versus pin sleep
        wr(7'h08, 8'h00);
        set_pin(1'b0);
        wr(7'h0e, 8'h60);
        wr(7'h0e, 8'h20);
        wr(7'h0e, 8'h60);
        wr(7'h0e, 8'h20);
        wr(7'h0e, 8'h00);
        wr(7'h0e, 8'h40);
        check_all();
        wr(7'h0e, 8'h80);
        set_pin(1'b1);
        check_all();
        wr(7'h0e, 8'h00);
        check_all();
        set_pin(1'b0);
        check_all();
        report_and_stop();
    end
endmodule
`default_nettype wire
